// ---- dtc_regs.svh ----
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_OFS_CS0 8'h00
`define DTC_OFS_RELOAD0 8'h04
`define DTC_OFS_COUNT0 8'h08
`define DTC_OFS_CS1 8'h10
`define DTC_OFS_RELOAD1 8'h14
`define DTC_OFS_COUNT1 8'h18
`define DTC_TIMER_STRIDE 8'h10

// bit labels, big-endian: label 0 is the msb
`define DTC_B_ALL 21
`define DTC_B_PWM 22
`define DTC_B_IRQF 23
`define DTC_B_RUN 24
`define DTC_B_IRQE 25
`define DTC_B_PRESET 26
`define DTC_B_RELOAD 27
`define DTC_B_CAPEN 28
`define DTC_B_GENEN 29
`define DTC_B_DOWN 30
`define DTC_B_MODE 31
`define DTC_B_RSV_LAST 20

`define DTC_CS_RESET 32'h0000_0000

`endif

// ---- dtc_pkg.sv ----
package dtc_pkg;

    typedef struct packed {
        logic capture_mode;
        logic count_down;
        logic gen_out_en;
        logic capture_trigger_en;
        logic reload_or_hold;
        logic preset_strobe;
        logic irq_enable;
        logic run;
        logic pulse_width_en;
    } dtc_ctrl_t;

    typedef struct packed {
        logic sel;
        logic rnw;
        logic [7:0] addr;
        logic [0:3] be;
        logic [0:31] wdata;
    } dtc_bus_req_t;

endpackage

// ---- dtc_timer_core.sv ----
`timescale 1ns/1ps
module dtc_timer_core import dtc_pkg::*; #(
    parameter int CW = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input dtc_ctrl_t i_ctrl,
    input wire logic [CW-1:0] i_reload_value,
    input wire logic i_restart,
    output logic [CW-1:0] o_count,
    output logic o_rollover
);

    logic [CW-1:0] cnt_q;
    logic held_q;
    logic [CW-1:0] term;
    logic loading;

    assign term = i_ctrl.count_down ? '0 : '1;
    assign loading = i_ctrl.preset_strobe || i_restart;
    assign o_count = cnt_q;
    assign o_rollover = i_ctrl.run && !loading && !i_ctrl.capture_mode && !held_q && cnt_q == term;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= '0;
            held_q <= 1'b0;
        end else if (loading) begin
            cnt_q <= i_reload_value;
            held_q <= 1'b0;
        end else if (i_ctrl.run) begin
            if (!i_ctrl.capture_mode && cnt_q == term) begin
                if (i_ctrl.reload_or_hold) begin
                    cnt_q <= i_reload_value;
                    held_q <= 1'b0;
                end else begin
                    held_q <= 1'b1;
                end
            end else if (i_ctrl.count_down) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    chk_halt_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !i_ctrl.run && !loading |=> cnt_q == $past(cnt_q))
        else $error("halted counter changed");
    chk_preset_load: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        i_ctrl.preset_strobe |=> cnt_q == $past(i_reload_value))
        else $error("preset did not load counter");
    chk_reload_run: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_rollover && i_ctrl.reload_or_hold |=> cnt_q == $past(i_reload_value))
        else $error("rollover did not reload");
    chk_hold_term: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_rollover && !i_ctrl.reload_or_hold |=> cnt_q == $past(cnt_q) && !o_rollover)
        else $error("counter left terminal value in hold");
    chk_count_dir: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        i_ctrl.run && !loading && i_ctrl.count_down && (i_ctrl.capture_mode || cnt_q != term)
        |=> cnt_q == CW'($past(cnt_q) - 1'b1))
        else $error("down count wrong");

endmodule

// ---- dtc_top.sv ----
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_top import dtc_pkg::*; #(
    parameter int CW = 32,
    parameter logic [1:0] GEN_POL = 2'h3,
    parameter logic [1:0] CAP_POL = 2'h3
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input dtc_bus_req_t i_bus_req,
    input wire logic [1:0] i_capture,
    output logic o_bus_ack,
    output logic [0:31] o_bus_rdata,
    output logic o_irq,
    output logic [1:0] o_gen_out,
    output logic o_pwm
);

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [0:31] merge_bytes(input logic [0:31] old_v, input logic [0:31] new_v,
                                                input logic [0:3] be);
        logic [0:31] r;
        r = old_v;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [0:31] cs_view(input dtc_ctrl_t c, input logic flag, input logic all_en);
        logic [0:31] r;
        r = `DTC_CS_RESET;
        r[`DTC_B_ALL] = all_en;
        r[`DTC_B_PWM] = c.pulse_width_en;
        r[`DTC_B_IRQF] = flag;
        r[`DTC_B_RUN] = c.run;
        r[`DTC_B_IRQE] = c.irq_enable;
        r[`DTC_B_PRESET] = c.preset_strobe;
        r[`DTC_B_RELOAD] = c.reload_or_hold;
        r[`DTC_B_CAPEN] = c.capture_trigger_en;
        r[`DTC_B_GENEN] = c.gen_out_en;
        r[`DTC_B_DOWN] = c.count_down;
        r[`DTC_B_MODE] = c.capture_mode;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic ack_q;
    logic [0:31] rdata_q;
    logic wr;
    logic rd;
    logic cs_hit;
    logic all_set;
    logic all_clr;
    logic enable_every_timer_q;

    assign wr = i_bus_req.sel && !i_bus_req.rnw && !ack_q;
    assign rd = i_bus_req.sel && i_bus_req.rnw && !ack_q;
    assign cs_hit = wr && (i_bus_req.addr == `DTC_OFS_CS0 || i_bus_req.addr == `DTC_OFS_CS1);
    assign all_set = cs_hit && i_bus_req.be[2] && i_bus_req.wdata[`DTC_B_ALL];
    assign all_clr = cs_hit && i_bus_req.be[2] && !i_bus_req.wdata[`DTC_B_ALL];

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enable_every_timer_q <= 1'b0;
        end else if (all_set) begin
            enable_every_timer_q <= 1'b1;
        end else if (all_clr) begin
            enable_every_timer_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-timer control, flag, reload register, capture input

    dtc_ctrl_t ctrl_q [2];
    logic [1:0] irqf_q;
    logic [1:0] lock_q;
    logic [CW-1:0] tlr_q [2];
    logic [CW-1:0] count [2];
    logic [1:0] rollover;
    logic [1:0] cap_evt;
    logic [1:0] irq_evt;
    logic [1:0] reload_rd;
    logic [1:0] reload_wr;
    logic [1:0] cs_wr;
    logic [1:0] cap_take;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam logic [7:0] BASE = 8'(i * `DTC_TIMER_STRIDE);
        logic [2:0] sync_q;
        logic lvl_q;
        logic [0:31] tlr_word;
        logic [0:31] tlr_new;
        logic [31:0] tlr_num;

        assign cs_wr[i] = wr && i_bus_req.addr == BASE + `DTC_OFS_CS0;
        assign reload_wr[i] = wr && i_bus_req.addr == BASE + `DTC_OFS_RELOAD0;
        assign reload_rd[i] = rd && i_bus_req.addr == BASE + `DTC_OFS_RELOAD0;
        assign tlr_word = 32'(tlr_q[i]);
        assign tlr_new = merge_bytes(tlr_word, i_bus_req.wdata, i_bus_req.be);
        assign tlr_num = tlr_new;

        // capture pin: three stages, level accepted when stages two and three agree
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                sync_q <= 3'h0;
                lvl_q <= 1'b0;
            end else begin
                sync_q <= {sync_q[1:0], i_capture[i] ~^ CAP_POL[i]};
                if (sync_q[1] == sync_q[2]) begin
                    lvl_q <= sync_q[2];
                end
            end
        end
        assign cap_evt[i] = sync_q[1] == sync_q[2] && sync_q[2] && !lvl_q;
        assign cap_take[i] = cap_evt[i] && ctrl_q[i].run && ctrl_q[i].capture_mode
                             && ctrl_q[i].capture_trigger_en && (ctrl_q[i].reload_or_hold || !lock_q[i]);
        assign irq_evt[i] = ctrl_q[i].run && (ctrl_q[i].capture_mode
                            ? cap_evt[i] && ctrl_q[i].capture_trigger_en : rollover[i]);

        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                ctrl_q[i] <= '0;
            end else begin
                if (all_set) begin
                    ctrl_q[i].run <= 1'b1;
                end else if (cs_wr[i] && i_bus_req.be[3]) begin
                    ctrl_q[i].run <= i_bus_req.wdata[`DTC_B_RUN];
                end
                if (cs_wr[i] && i_bus_req.be[2]) begin
                    ctrl_q[i].pulse_width_en <= i_bus_req.wdata[`DTC_B_PWM];
                end
                if (cs_wr[i] && i_bus_req.be[3]) begin
                    ctrl_q[i].irq_enable <= i_bus_req.wdata[`DTC_B_IRQE];
                    ctrl_q[i].preset_strobe <= i_bus_req.wdata[`DTC_B_PRESET];
                    ctrl_q[i].reload_or_hold <= i_bus_req.wdata[`DTC_B_RELOAD];
                    ctrl_q[i].capture_trigger_en <= i_bus_req.wdata[`DTC_B_CAPEN];
                    ctrl_q[i].gen_out_en <= i_bus_req.wdata[`DTC_B_GENEN];
                    ctrl_q[i].count_down <= i_bus_req.wdata[`DTC_B_DOWN];
                    ctrl_q[i].capture_mode <= i_bus_req.wdata[`DTC_B_MODE];
                end
            end
        end

        // flag: a new event wins over a same-cycle clear
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                irqf_q[i] <= 1'b0;
            end else if (irq_evt[i]) begin
                irqf_q[i] <= 1'b1;
            end else if (cs_wr[i] && i_bus_req.be[2] && i_bus_req.wdata[`DTC_B_IRQF]) begin
                irqf_q[i] <= 1'b0;
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                tlr_q[i] <= '0;
                lock_q[i] <= 1'b0;
            end else begin
                if (cap_take[i]) begin
                    tlr_q[i] <= count[i];
                end else if (reload_wr[i]) begin
                    tlr_q[i] <= tlr_num[CW-1:0];
                end
                if (cap_take[i]) begin
                    lock_q[i] <= 1'b1;
                end else if (reload_rd[i]) begin
                    lock_q[i] <= 1'b0;
                end
            end
        end

        dtc_timer_core #(.CW(CW)) u_core (
            .i_sys_clk(i_sys_clk),
            .i_arst_n(i_arst_n),
            .i_ctrl(ctrl_q[i]),
            .i_reload_value(tlr_q[i]),
            .i_restart(i == 1 && ctrl_q[0].pulse_width_en && rollover[0]),
            .o_count(count[i]),
            .o_rollover(rollover[i])
        );

        // generate output resets to 0 whatever GEN_POL, then idles at the inactive level while disabled
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                o_gen_out[i] <= 1'b0;
            end else begin
                o_gen_out[i] <= (ctrl_q[i].gen_out_en && rollover[i]) ? GEN_POL[i] : ~GEN_POL[i];
            end
        end

        chk_flag_needs_run: assert property ($rose(irqf_q[i]) |-> $past(ctrl_q[i].run))
            else $error("flag set while timer stopped");
        chk_flag_w1c: assert property (cs_wr[i] && i_bus_req.be[2] && i_bus_req.wdata[`DTC_B_IRQF]
            && !irq_evt[i] |=> !irqf_q[i])
            else $error("flag not cleared by write of one");
        chk_flag_set: assert property (irq_evt[i] |=> irqf_q[i])
            else $error("event did not set flag");
        chk_capture_held: assert property (lock_q[i] && !ctrl_q[i].reload_or_hold && !reload_rd[i]
            && !reload_wr[i] |=> tlr_q[i] == $past(tlr_q[i]))
            else $error("held capture overwritten");
        chk_capture_stores: assert property (cap_take[i]
            |=> tlr_q[i] == $past(count[i]))
            else $error("capture did not store count");
        chk_gen_pulse: assert property (ctrl_q[i].gen_out_en && rollover[i]
            |=> o_gen_out[i] == GEN_POL[i])
            else $error("generate output missed rollover");
        chk_gen_idle: assert property (!ctrl_q[i].gen_out_en
            |=> o_gen_out[i] == ~GEN_POL[i])
            else $error("disabled generate output active");
        chk_w0_keeps_flag: assert property (cs_wr[i] && i_bus_req.be[2] && !i_bus_req.wdata[`DTC_B_IRQF]
            && irqf_q[i] |=> irqf_q[i])
            else $error("flag lost on write of zero");
    end

    ////////////////////////////////////////////////////////////////////////////
    // paired pulse-width output

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pwm <= 1'b0;
        end else if (!ctrl_q[0].pulse_width_en) begin
            o_pwm <= 1'b0;
        end else if (rollover[0]) begin
            o_pwm <= 1'b1;
        end else if (rollover[1]) begin
            o_pwm <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and read path

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irqf_q & {ctrl_q[1].irq_enable, ctrl_q[0].irq_enable});
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= i_bus_req.sel && !ack_q;
            if (!rd) begin
                rdata_q <= '0;
            end else begin
                case (i_bus_req.addr)
                    `DTC_OFS_CS0: rdata_q <= cs_view(ctrl_q[0], irqf_q[0], enable_every_timer_q);
                    `DTC_OFS_CS1: rdata_q <= cs_view(ctrl_q[1], irqf_q[1], enable_every_timer_q);
                    `DTC_OFS_RELOAD0: rdata_q <= 32'(tlr_q[0]);
                    `DTC_OFS_RELOAD1: rdata_q <= 32'(tlr_q[1]);
                    `DTC_OFS_COUNT0: rdata_q <= 32'(count[0]);
                    `DTC_OFS_COUNT1: rdata_q <= 32'(count[1]);
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign o_bus_ack = ack_q;
    assign o_bus_rdata = rdata_q;

    chk_all_sets_runs: assert property (all_set |=> enable_every_timer_q && ctrl_q[0].run && ctrl_q[1].run)
        else $error("enable-all write did not start both timers");
    chk_all_clr_keeps: assert property (all_clr && !i_bus_req.be[3]
        |=> !enable_every_timer_q && $stable(ctrl_q[0].run) && $stable(ctrl_q[1].run))
        else $error("enable-all clear touched run enables");
    chk_all_mirror: assert property (rd && (i_bus_req.addr == `DTC_OFS_CS0 || i_bus_req.addr == `DTC_OFS_CS1)
        |=> o_bus_ack && o_bus_rdata[`DTC_B_ALL] == $past(enable_every_timer_q))
        else $error("enable-all not mirrored");
    chk_reserved_zero: assert property (rd && i_bus_req.addr == `DTC_OFS_CS1
        |=> o_bus_rdata[0:`DTC_B_RSV_LAST] == '0)
        else $error("reserved bits read nonzero");
    chk_irq_or: assert property (##1 o_irq == (($past(irqf_q[0]) && $past(ctrl_q[0].irq_enable))
        || ($past(irqf_q[1]) && $past(ctrl_q[1].irq_enable))))
        else $error("interrupt output not the enabled OR");
    chk_pwm_period: assert property (ctrl_q[0].pulse_width_en && rollover[0] |=> o_pwm)
        else $error("pulse-width output not raised at period start");
    chk_pwm_high_end: assert property (ctrl_q[0].pulse_width_en && !rollover[0] && rollover[1]
        |=> !o_pwm)
        else $error("pulse-width output not lowered at high-time end");
    chk_cs0_reserved: assert property (rd && i_bus_req.addr == `DTC_OFS_CS0
        |=> o_bus_rdata[0:`DTC_B_RSV_LAST] == '0)
        else $error("reserved bits of first register read nonzero");

endmodule

// ---- dtc_bus_master.sv ----
`timescale 1ns/1ps
module dtc_bus_master import dtc_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_bus_ack,
    input wire logic [0:31] i_bus_rdata,
    output dtc_bus_req_t o_bus_req
);
    initial begin
        o_bus_req = '0;
    end

    // request held up to the edge that samples ack, then released scrambled
    task automatic xfer(input logic rnw, input logic [7:0] addr, input logic [0:3] be,
                        input logic [0:31] wdata, output logic [0:31] rdata);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        #1;
        o_bus_req = '{1'b1, rnw, addr, be, wdata};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (i_bus_ack !== 1'b1 && n < 20);
        rdata = i_bus_rdata;
        #1;
        o_bus_req = '{1'b0, ~rnw, ~addr, ~be, ~wdata};
    endtask
endmodule

// ---- dtc_testbench.sv ----
`timescale 1ns/1ps
`include "dtc_regs.svh"
module testbench;
    import dtc_pkg::*;
    logic clk, rst_n, ack, irq, pwm;
    logic [1:0] cap, gen;
    logic [0:31] rdata;
    dtc_bus_req_t req;
    int fails, n_checks;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // both generate outputs active high; the paired pulse-width output is built from rollover and ignores them
    dtc_top #(.CW(8), .GEN_POL(2'h3), .CAP_POL(2'h3)) dut (
        .i_sys_clk(clk), .i_arst_n(rst_n), .i_bus_req(req), .i_capture(cap),
        .o_bus_ack(ack), .o_bus_rdata(rdata), .o_irq(irq), .o_gen_out(gen), .o_pwm(pwm));
    dtc_bus_master mst (.i_sys_clk(clk), .i_bus_ack(ack), .i_bus_rdata(rdata), .o_bus_req(req));

    ////////////////////////////////////////////////////////////////
    function automatic logic [0:31] lb(input int n);
        logic [0:31] v;
        v = '0;
        v[n] = 1'b1;
        return v;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [0:3] be, input logic [0:31] d);
        logic [0:31] x;
        mst.xfer(1'b0, a, be, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [0:31] d);
        mst.xfer(1'b1, a, 4'hf, '0, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [0:31] exp, input string what);
        logic [0:31] d;
        rd(a, d);
        chk(d, exp, what);
    endtask
    // counts falling edges until the watched output reaches lvl
    task automatic wait_lvl(input logic pw, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((pw ? pwm : gen[0]) !== lvl && n < 200);
    endtask
    task automatic pulse_cap;
        @(posedge clk);
        #1 cap[1] = 1'b1;
        repeat (4) @(posedge clk);
        #1 cap[1] = 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // two captures 41 cycles apart, then stored value against live count
    task automatic cap_pair(input logic [0:31] ctl, output logic [7:0] dif);
        logic [0:31] r, c;
        wr(`DTC_OFS_CS1, 4'h1, ctl);
        rd(`DTC_OFS_RELOAD1, r);
        pulse_cap();
        repeat (30) @(posedge clk);
        pulse_cap();
        rd(`DTC_OFS_RELOAD1, r);
        rd(`DTC_OFS_COUNT1, c);
        dif = c[24:31] - r[24:31];
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(`DTC_OFS_CS0, 32'h0, "cs0 after reset");
        rdc(`DTC_OFS_CS1, 32'h0, "cs1 after reset");
        wr(`DTC_OFS_CS1, 4'hf, 32'hFFFF_F800);
        rdc(`DTC_OFS_CS1, 32'h0, "reserved write");
        rdc(8'h0C, 32'h0, "unmapped read");
        $display("reset test done");
    endtask
    task automatic t_all;
        logic [0:31] a, b;
        wr(`DTC_OFS_CS0, 4'h3, lb(21));
        rdc(`DTC_OFS_CS0, lb(21) | lb(24), "enable all in cs0");
        rdc(`DTC_OFS_CS1, lb(21) | lb(24), "enable all in cs1");
        wr(`DTC_OFS_CS1, 4'h2, 32'h0);
        rdc(`DTC_OFS_CS0, lb(24), "zero clears only all");
        rd(`DTC_OFS_COUNT0, a);
        rd(`DTC_OFS_COUNT0, b);
        chk(a !== b, 1'b1, "count runs");
        wr(`DTC_OFS_CS0, 4'h1, 32'h0);
        wr(`DTC_OFS_CS1, 4'h1, 32'h0);
        rd(`DTC_OFS_COUNT0, a);
        repeat (5) @(posedge clk);
        rdc(`DTC_OFS_COUNT0, a, "halt keeps count");
        $display("enable test done");
    endtask
    task automatic t_gen;
        int n;
        wr(`DTC_OFS_RELOAD0, 4'hf, 32'h0000_00F0);
        wr(`DTC_OFS_CS0, 4'h1, lb(26));
        rdc(`DTC_OFS_COUNT0, 32'h0000_00F0, "preset load");
        wr(`DTC_OFS_CS0, 4'h1, lb(24) | lb(27));
        wait_lvl(1'b0, 1'b1, n);
        chk(n, 32'd200, "generate out off");
        chk(irq, 1'b0, "irq masked");
        wr(`DTC_OFS_CS0, 4'h1, lb(27));
        rdc(`DTC_OFS_CS0, lb(23) | lb(27), "flag while masked");
        wr(`DTC_OFS_CS0, 4'h2, 32'h0);
        rdc(`DTC_OFS_CS0, lb(23) | lb(27), "zero keeps flag");
        wr(`DTC_OFS_CS0, 4'h2, lb(23));
        rdc(`DTC_OFS_CS0, lb(27), "one clears flag");
        wr(`DTC_OFS_CS0, 4'h1, lb(24) | lb(25) | lb(27) | lb(29));
        wait_lvl(1'b0, 1'b1, n);
        wait_lvl(1'b0, 1'b1, n);
        chk(n, 32'd16, "reload period");
        repeat (2) @(negedge clk);
        chk(irq, 1'b1, "irq enabled");
        wr(`DTC_OFS_CS0, 4'h1, lb(24) | lb(25));
        repeat (40) @(posedge clk);
        rdc(`DTC_OFS_COUNT0, 32'h0000_00FF, "hold at terminal");
        wr(`DTC_OFS_CS0, 4'h3, lb(23));
        repeat (3) @(negedge clk);
        chk(irq, 1'b0, "irq drops");
        $display("generate test done");
    endtask
    task automatic t_down;
        logic [0:31] v;
        wr(`DTC_OFS_RELOAD0, 4'hf, 32'h0000_0010);
        wr(`DTC_OFS_CS0, 4'h1, lb(26) | lb(30));
        wr(`DTC_OFS_CS0, 4'h1, lb(24) | lb(30));
        rd(`DTC_OFS_COUNT0, v);
        chk(v < 32'h10 && v > 0, 1'b1, "counts down");
        repeat (30) @(posedge clk);
        rdc(`DTC_OFS_COUNT0, 32'h0, "holds at zero");
        rdc(`DTC_OFS_CS0, lb(23) | lb(24) | lb(30), "flag on underflow");
        wr(`DTC_OFS_CS0, 4'h3, lb(23));
        $display("down test done");
    endtask
    task automatic t_cap;
        logic [7:0] d;
        wr(`DTC_OFS_CS1, 4'h1, lb(28) | lb(31));
        pulse_cap();
        rdc(`DTC_OFS_CS1, lb(28) | lb(31), "no flag halted");
        wr(`DTC_OFS_CS1, 4'h1, lb(24) | lb(31));
        pulse_cap();
        rdc(`DTC_OFS_CS1, lb(24) | lb(31), "trigger ignored");
        cap_pair(lb(24) | lb(28) | lb(31), d);
        chk(d >= 8'd40, 1'b1, "hold keeps first");
        rdc(`DTC_OFS_CS1, lb(23) | lb(24) | lb(28) | lb(31), "capture flag");
        cap_pair(lb(24) | lb(27) | lb(28) | lb(31), d);
        chk(d < 8'd40, 1'b1, "overwrite keeps last");
        wr(`DTC_OFS_CS1, 4'h3, lb(23));
        $display("capture test done");
    endtask
    task automatic t_pwm;
        int h, l;
        wr(`DTC_OFS_RELOAD0, 4'hf, 32'h0000_00E0);
        wr(`DTC_OFS_RELOAD1, 4'hf, 32'h0000_00F0);
        wr(`DTC_OFS_CS0, 4'h1, lb(26));
        wr(`DTC_OFS_CS1, 4'h1, lb(26));
        wr(`DTC_OFS_CS1, 4'h3, lb(22) | lb(24) | lb(27) | lb(29));
        wr(`DTC_OFS_CS0, 4'h3, lb(22) | lb(24) | lb(27) | lb(29));
        wait_lvl(1'b1, 1'b0, h);
        wait_lvl(1'b1, 1'b1, h);
        wait_lvl(1'b1, 1'b0, h);
        wait_lvl(1'b1, 1'b1, l);
        chk(h, 32'd16, "pulse high time");
        chk(h + l, 32'd32, "pulse period");
        wr(`DTC_OFS_CS0, 4'h3, 32'h0);
        wr(`DTC_OFS_CS1, 4'h3, 32'h0);
        $display("pulse width test done");
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        cap = 2'b00;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_all();
        t_gen();
        t_down();
        t_cap();
        t_pwm();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end
endmodule
